// ---- ecim_pkg.sv ----
/*
 * Shared constants and types for the envelope cipher vector and mask block.
 * Assumes a single 40 MHz clock and 72-bit words of 8 flags and 8 octets.
 */
`default_nettype none

package ecim_pkg;

	// ----------------------------------------------------------------
	// Word and vector layout
	// ----------------------------------------------------------------
	localparam int WORD_W      = 72;
	localparam int DATA_W      = 64;
	localparam int CTRL_LSB    = 64;
	localparam int BLOCK_W     = 128;
	localparam int ADDR_W      = 48;
	localparam int TIME_W      = 48;
	localparam int LOCAL_W     = 32;
	localparam int LANE_FLD_W  = 16;
	localparam int BLKCNT_W    = 16;
	localparam int LEN_W       = 16;
	localparam int ALIGN_W     = 6;

	// ----------------------------------------------------------------
	// Counts and reset values
	// ----------------------------------------------------------------
	localparam int ECIM_LANES          = 4;
	localparam int ECIM_PACING_RUN     = 33;
	localparam int ECIM_CLK_NS         = 25;
	localparam int ECIM_TICK_NS        = 100;
	localparam int ECIM_TICK_CYCLES    =
		(ECIM_TICK_NS / ECIM_CLK_NS) < 1 ? 1 :
		(ECIM_TICK_NS / ECIM_CLK_NS);
	localparam logic [BLKCNT_W-1:0] BLKCNT_RST = 16'h0000;
	localparam logic [TIME_W-1:0]   TIME_RST   = 48'h0000_0000_0000;
	localparam logic [LEN_W-1:0]    LEN_RST    = 16'h0000;

	// ----------------------------------------------------------------
	// Word kinds on the stream
	// ----------------------------------------------------------------
	typedef enum logic [2:0] {
		KIND_HEADER,
		KIND_PAYLOAD,
		KIND_PACING,
		KIND_BETWEEN_ENV,
		KIND_BETWEEN_BURST
	} ecim_kind_t;

	// Octet mask of one word: FF for data, 00 for control octets
	function automatic logic [DATA_W-1:0] word_mask(
		input logic [7:0] flags);
		logic [DATA_W-1:0] m;
		m = '0;
		for (int i = 0; i < 8; i++) begin
			m[DATA_W-1-8*i -: 8] = flags[7-i] ? 8'h00 : 8'hFF;
		end
		return m;
	endfunction

endpackage

`default_nettype wire

// ---- ecim_time_if.sv ----
/*
 * Carrier of the protocol tick and both cipher times.
 * Assumes source and sink share the block clock.
 */
`timescale 1ns/1ps
`default_nettype none

interface ecim_time_if;
	logic                       tick;
	logic [ecim_pkg::TIME_W-1:0] tx_time;
	logic [ecim_pkg::TIME_W-1:0] rx_time;

	modport src (output tick, output tx_time, output rx_time);
	modport snk (input tick, input tx_time, input rx_time);
endinterface

`default_nettype wire

// ---- ecim_cipher_time.sv ----
/*
 * Transmit and receive cipher time counters with protocol tick divider.
 * Assumes the round-trip offset comes from same-clock logic.
 */
`timescale 1ns/1ps
`default_nettype none

module ecim_cipher_time
	import ecim_pkg::*;
#(
	parameter int TICK_CYCLES = ECIM_TICK_CYCLES
) (
	// Clock and reset
	input  wire logic              ref_clk_i,
	input  wire logic              rst_i,
	// Offset load
	input  wire logic [TIME_W-1:0] rtt_i,
	input  wire logic              rtt_load_i,
	// Times out
	ecim_time_if.src               time_if
);

	localparam int DIV_W = $clog2(TICK_CYCLES + 1);
	localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(TICK_CYCLES - 1);

	logic [DIV_W-1:0]  div_q;
	logic [TIME_W-1:0] tx_q;
	logic [TIME_W-1:0] rx_q;
	wire               tick = (div_q == DIV_LAST);

	// ----------------------------------------------------------------
	// Tick divider and counters
	// ----------------------------------------------------------------
	always_ff @(posedge ref_clk_i) begin
		if (rst_i) begin
			div_q <= '0;
		end else begin
			div_q <= tick ? '0 : div_q + 1'b1;
		end
	end

	// Carry from the low 32 bits runs into the 16-bit extension
	always_ff @(posedge ref_clk_i) begin
		if (rst_i) begin
			tx_q <= TIME_RST;
		end else if (tick) begin
			tx_q <= tx_q + 1'b1;
		end
	end

	// Separate counter, same tick, offset by the round trip
	always_ff @(posedge ref_clk_i) begin
		if (rst_i) begin
			rx_q <= TIME_RST;
		end else if (rtt_load_i) begin
			rx_q <= tx_q - rtt_i + (tick ? 1'b1 : 1'b0);
		end else if (tick) begin
			rx_q <= rx_q + 1'b1;
		end
	end

	assign time_if.tick    = tick;
	assign time_if.tx_time = tx_q;
	assign time_if.rx_time = rx_q;

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	chk_time_carry: assert property (
		@(posedge ref_clk_i) disable iff (rst_i)
		tick && tx_q[LOCAL_W-1:0] == 32'hFFFF_FFFF |=>
		tx_q[TIME_W-1:LOCAL_W] == $past(tx_q[TIME_W-1:LOCAL_W]) + 1'b1
		&& tx_q[LOCAL_W-1:0] == 32'h0000_0000)
		else $error("Cipher time extension missed a carry");

	chk_time_step: assert property (
		@(posedge ref_clk_i) disable iff (rst_i)
		tick |=> tx_q == $past(tx_q) + 48'h0000_0000_0001)
		else $error("Transmit cipher time did not step on tick");

	chk_rx_offset: assert property (
		@(posedge ref_clk_i) disable iff (rst_i)
		!rtt_load_i ##1 !rtt_load_i |->
		(tx_q - rx_q) == $past(tx_q - rx_q))
		else $error("Receive cipher time drifted from transmit time");

endmodule

`default_nettype wire

// ---- ecim_top.sv ----
/*
 * Per-lane vector derivation, block alignment and keystream masking.
 * Assumes an external cipher turns ctr_block_o into keystream_i in the
 * same cycle, and stream inputs come from logic on the same clock.
 */
`timescale 1ns/1ps
`default_nettype none

// Notes on behaviour
// - Transmit vector: lane, own station address, latched tx time, counter 0.
// - Receive vector: lane, head-end address, latched rx time, counter 0.
// - Receive vector is derived per lane whenever a header arrives there with dir_rx_i high.
// - Payload is handled as successive 128-bit cipher blocks.
// - Two payload words form a block; an odd last block holds one word.
// - First block starts right after the header; header passes unchanged.
// - Pacing filler comes in runs of 33 words for parity room.
// - Pacing filler bypasses the cipher and never shifts block alignment.
// - Pacing filler is left out of the tracked envelope length.
// - Between-envelope filler bypasses the cipher and leaves alignment alone.
// - Between-burst filler bypasses the cipher and leaves alignment alone.
// - Terminate and idle control characters pass through unmodified.
// - A word is 72 bits: 8 control flags and 8 octets.
// - Flag 1 marks a control octet left clear; others are enciphered.
// - Mask octet FF for data, 00 for control; all-control word gets zero.
// - Each word's mask fills its own half of a 128-bit keystream mask; the other half is zero.
// - Tx cipher time is 48 bits; low 32-bit carry bumps the top 16.
// - Rx cipher time is a separate 48-bit counter offset by round trip.
// - Vector derivation completes within one protocol tick of the header.
// - Transmit vector is derived per lane whenever a header arrives there with dir_rx_i low.
module ecim_top
	import ecim_pkg::*;
#(
	parameter int LANES       = ECIM_LANES,
	parameter int TICK_CYCLES = ECIM_TICK_CYCLES,
	parameter int LW          = (LANES > 1) ? $clog2(LANES) : 1
) (
	// Clock and reset
	input  wire logic                ref_clk_i,
	input  wire logic                rst_i,
	// Configuration
	input  wire logic                dir_rx_i,
	input  wire logic [ADDR_W-1:0]   station_address_i,
	input  wire logic [ADDR_W-1:0]   headend_address_i,
	input  wire logic [TIME_W-1:0]   rtt_i,
	input  wire logic                rtt_load_i,
	// Stream in
	input  wire logic                in_valid_i,
	input  wire ecim_kind_t          in_kind_i,
	input  wire logic [LW-1:0]       in_lane_i,
	input  wire logic [WORD_W-1:0]   in_word_i,
	// Cipher core
	output logic [BLOCK_W-1:0]       ctr_block_o,
	input  wire logic [BLOCK_W-1:0]  keystream_i,
	// Stream out
	output logic                     out_valid_o,
	output ecim_kind_t               out_kind_o,
	output logic [LW-1:0]            out_lane_o,
	output logic [WORD_W-1:0]        out_word_o,
	output logic                     out_ciphered_o,
	output logic [LEN_W-1:0]         env_len_o,
	output logic                     pacing_short_o,
	// Cipher times
	output logic [TIME_W-1:0]        tx_time_o,
	output logic [TIME_W-1:0]        rx_time_o
);

	// ----------------------------------------------------------------
	// Cipher times
	// ----------------------------------------------------------------
	ecim_time_if time_if ();

	ecim_cipher_time #(
		.TICK_CYCLES (TICK_CYCLES)
	) u_time (
		.ref_clk_i  (ref_clk_i),
		.rst_i      (rst_i),
		.rtt_i      (rtt_i),
		.rtt_load_i (rtt_load_i),
		.time_if    (time_if)
	);

	assign tx_time_o = time_if.tx_time;
	assign rx_time_o = time_if.rx_time;

	// ----------------------------------------------------------------
	// Per-lane state, and one pacing run counter shared by all lanes
	// ----------------------------------------------------------------
	logic [TIME_W-1:0]   ts_q   [LANES];
	logic [BLKCNT_W-1:0] blk_q  [LANES];
	logic                half_q [LANES];
	logic                env_q  [LANES];
	logic [LEN_W-1:0]    len_q  [LANES];
	logic [5:0]          pace_q;

	// ----------------------------------------------------------------
	// Decode and selection
	// ----------------------------------------------------------------
	wire                is_hdr  = in_valid_i && in_kind_i == KIND_HEADER;
	wire                is_pay  = in_valid_i && in_kind_i == KIND_PAYLOAD
	                              && env_q[in_lane_i];
	wire                is_pace = in_valid_i && in_kind_i == KIND_PACING;
	wire                is_gap  = in_valid_i
	                              && (in_kind_i == KIND_BETWEEN_ENV
	                              || in_kind_i == KIND_BETWEEN_BURST);
	wire [TIME_W-1:0]   hdr_time = dir_rx_i ? time_if.rx_time
	                                        : time_if.tx_time;
	wire [ADDR_W-1:0]   addr_sel = dir_rx_i ? headend_address_i
	                                        : station_address_i;
	wire                cur_half = half_q[in_lane_i];
	wire [DATA_W-1:0]   wmask    = word_mask(in_word_i[WORD_W-1:CTRL_LSB]);
	wire [BLOCK_W-1:0]  blk_mask = cur_half ? {64'h0000_0000_0000_0000, wmask}
	                                        : {wmask, 64'h0000_0000_0000_0000};
	wire [BLOCK_W-1:0]  ks_mask  = keystream_i & blk_mask;
	wire [DATA_W-1:0]   ks_word  = cur_half ? ks_mask[DATA_W-1:0]
	                                        : ks_mask[BLOCK_W-1:DATA_W];
	wire [DATA_W-1:0]   data_out = is_pay ? in_word_i[DATA_W-1:0] ^ ks_word
	                                      : in_word_i[DATA_W-1:0];
	wire                pace_end = !is_pace && in_valid_i && pace_q != 6'h00;

	// Counter-mode input of the block the current word belongs to
	assign ctr_block_o = {LANE_FLD_W'(in_lane_i), addr_sel,
		ts_q[in_lane_i], blk_q[in_lane_i]};

	// ----------------------------------------------------------------
	// Lane state update
	// ----------------------------------------------------------------
	always_ff @(posedge ref_clk_i) begin
		if (rst_i) begin
			for (int l = 0; l < LANES; l++) begin
				ts_q[l]   <= TIME_RST;
				blk_q[l]  <= BLKCNT_RST;
				half_q[l] <= 1'b0;
				env_q[l]  <= 1'b0;
				len_q[l]  <= LEN_RST;
			end
		end else if (is_hdr) begin
			ts_q[in_lane_i]   <= hdr_time;
			blk_q[in_lane_i]  <= BLKCNT_RST;
			half_q[in_lane_i] <= 1'b0;
			env_q[in_lane_i]  <= 1'b1;
			len_q[in_lane_i]  <= LEN_RST;
		end else if (is_pay) begin
			half_q[in_lane_i] <= !cur_half;
			len_q[in_lane_i]  <= len_q[in_lane_i] + 1'b1;
			if (cur_half) begin
				blk_q[in_lane_i] <= blk_q[in_lane_i] + 1'b1;
			end
		end else if (is_gap) begin
			env_q[in_lane_i] <= 1'b0;
		end
	end

	// Pacing run length watch
	always_ff @(posedge ref_clk_i) begin
		if (rst_i) begin
			pace_q <= 6'h00;
		end else if (is_pace && pace_q != 6'h3F) begin
			pace_q <= pace_q + 1'b1;
		end else if (is_pace) begin
			// Saturate so an overlong run still ends as short
			pace_q <= pace_q;
		end else if (in_valid_i) begin
			pace_q <= 6'h00;
		end
	end

	// ----------------------------------------------------------------
	// Output stage
	// ----------------------------------------------------------------
	always_ff @(posedge ref_clk_i) begin
		if (rst_i) begin
			out_valid_o    <= 1'b0;
			out_kind_o     <= KIND_BETWEEN_BURST;
			out_lane_o     <= '0;
			out_word_o     <= '0;
			out_ciphered_o <= 1'b0;
			env_len_o      <= LEN_RST;
			pacing_short_o <= 1'b0;
		end else begin
			out_valid_o    <= in_valid_i;
			out_kind_o     <= in_kind_i;
			out_lane_o     <= in_lane_i;
			// Flags always copied; only data octets can change
			out_word_o     <= {in_word_i[WORD_W-1:CTRL_LSB],
				data_out};
			out_ciphered_o <= is_pay;
			env_len_o      <= is_pay ? len_q[in_lane_i] + 1'b1
			                         : len_q[in_lane_i];
			pacing_short_o <= pace_end
				&& pace_q != 6'(ECIM_PACING_RUN);
		end
	end

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	chk_hdr_tx_time: assert property (
		@(posedge ref_clk_i) disable iff (rst_i)
		is_hdr && !dir_rx_i |=>
		ts_q[$past(in_lane_i)] == $past(time_if.tx_time)
		&& blk_q[$past(in_lane_i)] == BLKCNT_RST)
		else $error("Transmit vector not latched from tx time");

	chk_hdr_rx_time: assert property (
		@(posedge ref_clk_i) disable iff (rst_i)
		is_hdr && dir_rx_i |=>
		ts_q[$past(in_lane_i)] == $past(time_if.rx_time)
		&& blk_q[$past(in_lane_i)] == BLKCNT_RST)
		else $error("Receive vector not latched from rx time");

	chk_hdr_bypass: assert property (
		@(posedge ref_clk_i) disable iff (rst_i)
		is_hdr |=> !out_ciphered_o
		&& out_word_o == $past(in_word_i))
		else $error("Header word was altered");

	chk_filler_bypass: assert property (
		@(posedge ref_clk_i) disable iff (rst_i)
		(is_pace || is_gap) |=> !out_ciphered_o
		&& out_word_o == $past(in_word_i)
		&& env_len_o == $past(len_q[in_lane_i]))
		else $error("Filler word was altered or counted");

	chk_align_hold: assert property (
		@(posedge ref_clk_i) disable iff (rst_i)
		(is_pace || is_gap) |=>
		half_q[$past(in_lane_i)] == $past(half_q[in_lane_i])
		&& blk_q[$past(in_lane_i)] == $past(blk_q[in_lane_i]))
		else $error("Filler shifted block alignment");

	chk_ctrl_clear: assert property (
		@(posedge ref_clk_i) disable iff (rst_i)
		in_valid_i |=> ((out_word_o[DATA_W-1:0] ^ $past(in_word_i[DATA_W-1:0]))
		& ~word_mask(out_word_o[WORD_W-1:CTRL_LSB])) == '0
		&& out_word_o[WORD_W-1:CTRL_LSB]
		== $past(in_word_i[WORD_W-1:CTRL_LSB]))
		else $error("Control octet or flag was changed");

	chk_pay_xor: assert property (
		@(posedge ref_clk_i) disable iff (rst_i)
		is_pay && !cur_half |=> out_word_o[DATA_W-1:0]
		== ($past(in_word_i[DATA_W-1:0]) ^ ($past(keystream_i[BLOCK_W-1:DATA_W])
		& word_mask($past(in_word_i[WORD_W-1:CTRL_LSB])))))
		else $error("First word of block used wrong keystream half");

	chk_block_step: assert property (
		@(posedge ref_clk_i) disable iff (rst_i)
		is_pay && cur_half |=>
		blk_q[$past(in_lane_i)] == $past(blk_q[in_lane_i]) + 1'b1
		&& !half_q[$past(in_lane_i)])
		else $error("Block counter did not step after second word");

	chk_pace_run: assert property (
		@(posedge ref_clk_i) disable iff (rst_i)
		pace_end && pace_q == 6'(ECIM_PACING_RUN) |=> !pacing_short_o)
		else $error("Full pacing run flagged short");

	chk_pace_short: assert property (
		@(posedge ref_clk_i) disable iff (rst_i)
		pace_end && pace_q != 6'(ECIM_PACING_RUN) |=> pacing_short_o)
		else $error("Short pacing run not flagged");

	chk_pay_xor_lo: assert property (
		@(posedge ref_clk_i) disable iff (rst_i)
		is_pay && cur_half |=> out_word_o[DATA_W-1:0]
		== ($past(in_word_i[DATA_W-1:0]) ^ ($past(keystream_i[DATA_W-1:0])
		& word_mask($past(in_word_i[WORD_W-1:CTRL_LSB])))))
		else $error("Second word of block used wrong keystream half");

	chk_len_count: assert property (
		@(posedge ref_clk_i) disable iff (rst_i)
		is_pay |=> env_len_o == $past(len_q[in_lane_i]) + 1'b1)
		else $error("Envelope length missed a payload word");

	chk_gap_close: assert property (
		@(posedge ref_clk_i) disable iff (rst_i)
		is_gap |=> !env_q[$past(in_lane_i)])
		else $error("Filler between envelopes left envelope open");

	chk_pay_plain: assert property (
		@(posedge ref_clk_i) disable iff (rst_i)
		in_valid_i && in_kind_i == KIND_PAYLOAD && !env_q[in_lane_i] |=>
		!out_ciphered_o && out_word_o == $past(in_word_i))
		else $error("Payload outside an envelope was altered");

	chk_out_follow: assert property (
		@(posedge ref_clk_i) disable iff (rst_i)
		!$past(rst_i) |-> out_valid_o == $past(in_valid_i)
		&& out_kind_o == $past(in_kind_i) && out_lane_o == $past(in_lane_i))
		else $error("Output stage lost step with input");

	cov_header: cover property (@(posedge ref_clk_i) disable iff (rst_i)
		is_hdr ##2 is_pay ##2 is_pay);
	cov_pace_mid: cover property (@(posedge ref_clk_i) disable iff (rst_i)
		is_pay && !cur_half ##2 is_pace);
	cov_odd_tail: cover property (@(posedge ref_clk_i) disable iff (rst_i)
		is_pay && !cur_half ##2 is_gap);
	cov_tick_hdr: cover property (@(posedge ref_clk_i) disable iff (rst_i)
		is_hdr && time_if.tick);

endmodule

`default_nettype wire

// ---- ecim_ks_model.sv ----
/*
 * Keystream source standing in for the block cipher core.
 * Assumes the answer is needed in the same cycle as the counter block.
 */
`timescale 1ns/1ps
`default_nettype none

module ecim_ks_model
	import ecim_pkg::*;
(
	// Counter block in
	input  wire logic [BLOCK_W-1:0] ctr_block_i,
	// Keystream out
	output logic [BLOCK_W-1:0]      keystream_o
);
	// ------------------------------------------------------------
	// Fixed scramble, different in each half
	// ------------------------------------------------------------
	assign keystream_o = {ctr_block_i[63:0], ctr_block_i[127:64]} ^
		128'h5A3C_96E1_0F87_C3D2_A569_1E4B_7D28_F0B4;
endmodule

`default_nettype wire

// ---- tb_top.sv ----
/*
 * Self-checking bench for the envelope cipher vector and mask block.
 * Assumes the keystream model file is compiled before this one.
 */
`timescale 1ns/1ps
`default_nettype none

module tb_top
	import ecim_pkg::*;
;
	// ------------------------------------------------------------
	// Signals
	// ------------------------------------------------------------
	localparam logic [47:0] STA = 48'h0A1B_2C3D_4E5F;
	localparam logic [47:0] HEA = 48'h6071_8293_A4B5;
	logic              ref_clk_i = 1'b0;
	logic              rst_i     = 1'b1;
	logic              dir_rx_i  = 1'b0;
	logic [47:0]       rtt_i     = 48'h0000_0000_0000;
	logic              rtt_load_i = 1'b0;
	logic              in_valid_i = 1'b0;
	ecim_kind_t        in_kind_i  = KIND_BETWEEN_BURST;
	logic [1:0]        in_lane_i  = 2'h0;
	logic [71:0]       in_word_i  = '0;
	logic [127:0]      ctr_block, keystream;
	logic              out_valid_o, out_ciphered_o, pacing_short_o;
	ecim_kind_t        out_kind_o;
	logic [1:0]        out_lane_o;
	logic [71:0]       out_word_o;
	logic [15:0]       env_len_o;
	logic [47:0]       tx_time_o, rx_time_o;
	logic [127:0]      cur_ctr;
	logic [47:0]       cur_tx, cur_rx;
	ecim_kind_t        cur_kind;
	logic [1:0]        cur_lane;
	int                err_count = 0;
	int                checked = 0;

	always #12.5 ref_clk_i = ~ref_clk_i;

	ecim_top #(.TICK_CYCLES(2)) dut_u (
		.ref_clk_i(ref_clk_i), .rst_i(rst_i), .dir_rx_i(dir_rx_i),
		.station_address_i(STA), .headend_address_i(HEA),
		.rtt_i(rtt_i), .rtt_load_i(rtt_load_i),
		.in_valid_i(in_valid_i), .in_kind_i(in_kind_i),
		.in_lane_i(in_lane_i), .in_word_i(in_word_i),
		.ctr_block_o(ctr_block), .keystream_i(keystream),
		.out_valid_o(out_valid_o), .out_kind_o(out_kind_o),
		.out_lane_o(out_lane_o), .out_word_o(out_word_o),
		.out_ciphered_o(out_ciphered_o), .env_len_o(env_len_o),
		.pacing_short_o(pacing_short_o),
		.tx_time_o(tx_time_o), .rx_time_o(rx_time_o));

	ecim_ks_model ks_u (.ctr_block_i(ctr_block), .keystream_o(keystream));

	// ------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------
	task automatic cmp(input logic [127:0] got, input logic [127:0] exp);
		checked++;
		if (got !== exp) begin
			err_count++;
			$display("unexpected at %0t: got %h exp %h", $time, got, exp);
		end
	endtask

	function automatic logic [63:0] msk(input logic [7:0] f);
		logic [63:0] m;
		for (int i = 0; i < 8; i++) begin
			m[63-8*i -: 8] = f[7-i] ? 8'h00 : 8'hFF;
		end
		return m;
	endfunction

	function automatic logic [127:0] ks(input logic [127:0] c);
		return {c[63:0], c[127:64]} ^ 128'h5A3C_96E1_0F87_C3D2_A569_1E4B_7D28_F0B4;
	endfunction

	task automatic put(input ecim_kind_t k, input logic [1:0] ln,
		input logic [71:0] w);
		@(posedge ref_clk_i);
		in_valid_i <= 1'b1;
		in_kind_i  <= k;
		in_lane_i  <= ln;
		in_word_i  <= w;
		#1;
		cur_ctr = ctr_block;
		cur_tx  = tx_time_o;
		cur_rx  = rx_time_o;
		cur_kind = k;
		cur_lane = ln;
		@(posedge ref_clk_i);
		in_valid_i <= 1'b0;
		#1;
	endtask

	task automatic chk_out(input logic [71:0] w, input logic c);
		cmp({127'h0, out_valid_o}, 128'h1);
		cmp({56'h0, out_word_o}, {56'h0, w});
		cmp({127'h0, out_ciphered_o}, {127'h0, c});
		cmp({125'h0, out_kind_o}, {125'h0, cur_kind});
		cmp({126'h0, out_lane_o}, {126'h0, cur_lane});
	endtask

	// ------------------------------------------------------------
	// Scenarios
	// ------------------------------------------------------------
	task automatic t_times();
		logic [47:0] a;
		logic [47:0] d;
		a = tx_time_o;
		repeat (16) @(posedge ref_clk_i);
		#1;
		cmp(tx_time_o - a, 128'h8);
		@(posedge ref_clk_i);
		rtt_i      <= 48'h0000_0000_0123;
		rtt_load_i <= 1'b1;
		@(posedge ref_clk_i);
		rtt_load_i <= 1'b0;
		repeat (5) @(posedge ref_clk_i);
		#1;
		d = tx_time_o - rx_time_o;
		cmp({80'h0, d}, 128'h123);
		$display("test times done");
	endtask

	task automatic t_tx_env();
		logic [71:0] h, a, b, c, p;
		logic [127:0] e, k;
		logic [47:0] th;
		h = 72'h00_4845_4144_4552_0001;
		a = 72'h00_1111_2222_3333_4444;
		b = 72'h1F_ABCD_EFFD_0707_0707;
		c = 72'h00_5555_6666_7777_8888;
		p = 72'hFF_1C1C_1C1C_1C1C_1C1C;
		put(KIND_HEADER, 2'h2, h);
		th = cur_tx;
		chk_out(h, 1'b0);
		put(KIND_PAYLOAD, 2'h2, a);
		// Vector holds the tx time seen while the header stood
		e = {16'h0002, STA, th, 16'h0000};
		cmp(cur_ctr, e);
		cmp(cur_ctr[15:0], 128'h0);
		k = ks(e);
		chk_out({a[71:64], a[63:0] ^ (k[127:64] & msk(a[71:64]))}, 1'b1);
		cmp(env_len_o, 128'h1);
		repeat (33) begin
			put(KIND_PACING, 2'h2, p);
			chk_out(p, 1'b0);
			cmp(env_len_o, 128'h1);
		end
		put(KIND_PAYLOAD, 2'h2, b);
		cmp(cur_ctr, e);
		chk_out({b[71:64], b[63:0] ^ (k[63:0] & msk(b[71:64]))}, 1'b1);
		cmp({127'h0, pacing_short_o}, 128'h0);
		put(KIND_PAYLOAD, 2'h2, c);
		e[15:0] = 16'h0001;
		cmp(cur_ctr, e);
		k = ks(e);
		chk_out({c[71:64], c[63:0] ^ (k[127:64] & msk(c[71:64]))}, 1'b1);
		cmp(env_len_o, 128'h3);
		put(KIND_BETWEEN_ENV, 2'h2, p);
		chk_out(p, 1'b0);
		put(KIND_PAYLOAD, 2'h2, a);
		chk_out(a, 1'b0);
		$display("test transmit envelope done");
	endtask

	task automatic t_rx_env();
		logic [71:0] h, i, a;
		logic [127:0] e, k;
		logic [47:0] th;
		h = 72'h00_0102_0304_0506_0708;
		i = 72'hFF_0707_0707_0707_0707;
		a = 72'h03_9988_7766_5544_FD07;
		@(posedge ref_clk_i);
		dir_rx_i <= 1'b1;
		put(KIND_HEADER, 2'h1, h);
		th = cur_rx;
		chk_out(h, 1'b0);
		put(KIND_PAYLOAD, 2'h1, i);
		e = {16'h0001, HEA, th, 16'h0000};
		cmp(cur_ctr, e);
		cmp(cur_ctr[15:0], 128'h0);
		chk_out(i, 1'b1);
		repeat (2) begin
			put(KIND_PACING, 2'h1, i);
			chk_out(i, 1'b0);
		end
		put(KIND_PAYLOAD, 2'h1, a);
		cmp(cur_ctr, e);
		cmp({127'h0, pacing_short_o}, 128'h1);
		k = ks(e);
		chk_out({a[71:64], a[63:0] ^ (k[63:0] & msk(a[71:64]))}, 1'b1);
		cmp(env_len_o, 128'h2);
		put(KIND_BETWEEN_BURST, 2'h1, i);
		chk_out(i, 1'b0);
		put(KIND_PAYLOAD, 2'h1, a);
		chk_out(a, 1'b0);
		$display("test receive envelope done");
	endtask

	// ------------------------------------------------------------
	// Run control
	// ------------------------------------------------------------
	task automatic conclude();
		$display("comparisons %0d mismatches %0d", checked, err_count);
		if (err_count == 0 && checked > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask

	initial begin
		repeat (20) @(posedge ref_clk_i);
		rst_i <= 1'b0;
		t_times();
		t_tx_env();
		t_rx_env();
		conclude();
	end

	initial begin
		#(25 * 5000);
		err_count++;
		conclude();
	end
endmodule

`default_nettype wire
